//--- logic/rtoc_timer.v
// Top of the 16-bit reload timer, one-shot and continuous modes, APB slave.
// Assumes a same-clock APB master; no pin inputs, so nothing is synchronised.
`timescale 1ns/1ps
`include "rtoc_consts.vh"

module rtoc_timer
(
	input wire clk,
	input wire rstn,
	input wire ce,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	output reg tout,
	output reg tout_oe_n,
	output wire irq
);

// ****************************************
// Functions
// ****************************************
function mode_ok;
	input [2:0] mode;
	begin
		mode_ok = (mode == `RTOC_MODE_ONESHOT) || (mode == `RTOC_MODE_CONT);
	end
endfunction

// One-hot register select; zero for an unmapped or misaligned address
function [4:0] reg_decode;
	input [7:0] addr;
	begin
		case (addr)
			`RTOC_OFF_CTRL:
				reg_decode = 5'h01;
			`RTOC_OFF_COUNT:
				reg_decode = 5'h02;
			`RTOC_OFF_RELOAD:
				reg_decode = 5'h04;
			`RTOC_OFF_STATUS:
				reg_decode = 5'h08;
			`RTOC_OFF_MASK:
				reg_decode = 5'h10;
			default:
				reg_decode = 5'h00;
		endcase
	end
endfunction

function addr_hit;
	input [7:0] addr;
	begin
		addr_hit = |reg_decode(addr);
	end
endfunction

// ****************************************
// Declarations
// ****************************************
reg ctrl_en;
reg output_polarity;
reg [2:0] prescale_select;
reg [2:0] timer_mode_select;
reg [15:0] count;
reg [15:0] reload;
reg [31:0] read_mux;
wire apb_acc;
wire apb_wr;
wire wr_ctrl;
wire wr_count;
wire wr_reload;
wire wr_status;
wire wr_mask;
wire running;
wire ptick;
wire [15:0] count_inc;
wire hit;
wire is_oneshot;
wire stat_evt;
wire mask_evt;
wire [4:0] reg_sel;
reg next_pready;
reg [31:0] next_prdata;
reg next_pslverr;
reg [15:0] next_count;
reg next_ctrl_en;
reg next_output_polarity;
reg [2:0] next_prescale_select;
reg [2:0] next_timer_mode_select;
reg next_tout_oe_n;
reg [15:0] next_reload;

// Bit positions in the one-hot register select
localparam SEL_CTRL = 0;
localparam SEL_COUNT = 1;
localparam SEL_RELOAD = 2;
localparam SEL_STATUS = 3;
localparam SEL_MASK = 4;

// ****************************************
// APB slave
// ****************************************
// One wait state: read data and the error come from flops
assign apb_acc = psel & penable;
assign apb_wr = apb_acc & pready & pwrite;
assign reg_sel = reg_decode(paddr);
assign wr_ctrl = apb_wr & reg_sel[SEL_CTRL];
assign wr_count = apb_wr & reg_sel[SEL_COUNT];
assign wr_reload = apb_wr & reg_sel[SEL_RELOAD];
assign wr_status = apb_wr & reg_sel[SEL_STATUS];
assign wr_mask = apb_wr & reg_sel[SEL_MASK];

always @*
begin
	read_mux = 32'h00000000;
	case (paddr)
		`RTOC_OFF_CTRL:
		begin
			read_mux[`RTOC_CTRL_MODE_MSB:`RTOC_CTRL_MODE_LSB] = timer_mode_select;
			read_mux[`RTOC_CTRL_PS_MSB:`RTOC_CTRL_PS_LSB] = prescale_select;
			read_mux[`RTOC_CTRL_POL] = output_polarity;
			read_mux[`RTOC_CTRL_EN] = ctrl_en;
			read_mux[`RTOC_CTRL_OUTEN] = ~tout_oe_n;
		end
		`RTOC_OFF_COUNT:
			read_mux[15:0] = count;
		`RTOC_OFF_RELOAD:
			read_mux[15:0] = reload;
		`RTOC_OFF_STATUS:
		begin
			read_mux[`RTOC_STAT_EVT] = stat_evt;
			read_mux[`RTOC_STAT_RUN] = running;
		end
		`RTOC_OFF_MASK:
			read_mux[`RTOC_STAT_EVT] = mask_evt;
		default:
			read_mux = 32'h00000000;
	endcase
end

// The answer is formed in the first access cycle and stands for exactly one cycle
always @*
begin
	next_pready = apb_acc & ~pready;
	next_prdata = 32'h00000000;
	next_pslverr = 1'b0;
	if (apb_acc & ~pready)
	begin
		next_prdata = pwrite ? 32'h00000000 : read_mux;
		next_pslverr = ~addr_hit(paddr);
	end
end

always @(posedge clk)
begin
	if (!rstn)
	begin
		pready <= 1'b0;
		prdata <= 32'h00000000;
		pslverr <= 1'b0;
	end
	else if (ce)
	begin
		pready <= next_pready;
		prdata <= next_prdata;
		pslverr <= next_pslverr;
	end
end

// ****************************************
// Count engine
// ****************************************
// Other mode codes are not built here; the counter simply holds
assign running = ctrl_en & mode_ok(timer_mode_select);
assign is_oneshot = (timer_mode_select == `RTOC_MODE_ONESHOT);
assign count_inc = count + 16'h0001;
// Matching the incremented value makes the interval exactly reload - start ticks
assign hit = ptick & (count_inc == reload);

rtoc_prescaler u_prescaler
(
	.clk(clk),
	.rstn(rstn),
	.ce(ce),
	.run(running),
	.prescale_select(prescale_select),
	.tick(ptick)
);

always @*
begin
	next_count = count;
	// A software write to the count wins over the increment
	if (wr_count)
		next_count = pwdata[15:0];
	else if (hit)
		next_count = `RTOC_RELOAD_START;
	else if (ptick)
		next_count = count_inc;
end

always @(posedge clk)
begin
	if (!rstn)
		count <= `RTOC_RST_COUNT;
	else if (ce)
		count <= next_count;
end

// ****************************************
// Control and reload registers
// ****************************************
always @*
begin
	next_ctrl_en = ctrl_en;
	next_output_polarity = output_polarity;
	next_prescale_select = prescale_select;
	next_timer_mode_select = timer_mode_select;
	next_tout_oe_n = tout_oe_n;
	next_reload = reload;
	// Software wins over the one-shot self-disable in the same cycle
	if (wr_ctrl)
	begin
		next_timer_mode_select = pwdata[`RTOC_CTRL_MODE_MSB:`RTOC_CTRL_MODE_LSB];
		next_prescale_select = pwdata[`RTOC_CTRL_PS_MSB:`RTOC_CTRL_PS_LSB];
		next_output_polarity = pwdata[`RTOC_CTRL_POL];
		next_ctrl_en = pwdata[`RTOC_CTRL_EN];
		next_tout_oe_n = ~pwdata[`RTOC_CTRL_OUTEN];
	end
	else if (hit & is_oneshot)
		next_ctrl_en = 1'b0;
	if (wr_reload)
		next_reload = pwdata[15:0];
end

always @(posedge clk)
begin
	if (!rstn)
	begin
		ctrl_en <= 1'b0;
		output_polarity <= 1'b0;
		prescale_select <= 3'h0;
		timer_mode_select <= 3'h0;
		tout_oe_n <= 1'b1;
		reload <= `RTOC_RST_RELOAD;
	end
	else if (ce)
	begin
		ctrl_en <= next_ctrl_en;
		output_polarity <= next_output_polarity;
		prescale_select <= next_prescale_select;
		timer_mode_select <= next_timer_mode_select;
		tout_oe_n <= next_tout_oe_n;
		reload <= next_reload;
	end
end

// ****************************************
// Timer output pin
// ****************************************
// While stopped the pin shows the polarity bit, so software sets the start level
always @(posedge clk)
begin
	if (!rstn)
		tout <= 1'b0;
	else if (ce)
	begin
		if (!running)
			tout <= output_polarity;
		else if (hit)
			tout <= ~tout;
	end
end

// ****************************************
// Interrupt
// ****************************************
rtoc_irq u_irq
(
	.clk(clk),
	.rstn(rstn),
	.ce(ce),
	.event_pulse(hit),
	.status_w1c(wr_status & pwdata[`RTOC_STAT_EVT]),
	.mask_we(wr_mask),
	.mask_wdata(pwdata[`RTOC_STAT_EVT]),
	.status(stat_evt),
	.mask(mask_evt),
	.irq(irq)
);

endmodule

//--- logic/rtoc_consts.vh
// Constants for the reload timer: APB offsets, field positions, reset values.
// Assumes byte addressing on an 8-bit APB address with 32-bit data words.
`ifndef RTOC_CONSTS_VH
`define RTOC_CONSTS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define RTOC_OFF_CTRL 8'h00
`define RTOC_OFF_COUNT 8'h04
`define RTOC_OFF_RELOAD 8'h08
`define RTOC_OFF_STATUS 8'h0C
`define RTOC_OFF_MASK 8'h10

// ****************************************
// Control field positions
// ****************************************
`define RTOC_CTRL_MODE_LSB 0
`define RTOC_CTRL_MODE_MSB 2
`define RTOC_CTRL_PS_LSB 3
`define RTOC_CTRL_PS_MSB 5
`define RTOC_CTRL_POL 6
`define RTOC_CTRL_EN 7
`define RTOC_CTRL_OUTEN 8

// ****************************************
// Status field positions
// ****************************************
`define RTOC_STAT_EVT 0
`define RTOC_STAT_RUN 1

// ****************************************
// Mode codes
// ****************************************
`define RTOC_MODE_ONESHOT 3'h0
`define RTOC_MODE_CONT 3'h1

// ****************************************
// Reset and load values, prescaler counter width
// ****************************************
`define RTOC_RST_COUNT 16'h0000
`define RTOC_RST_RELOAD 16'hFFFF
`define RTOC_RELOAD_START 16'h0001
`define RTOC_PSC_W 7

`endif

//--- logic/rtoc_prescaler.v
// Prescaler for the reload timer: divides clk by 2**prescale_select.
// Assumes run is a same-clock level; the count is cleared while run is low.
`timescale 1ns/1ps
`include "rtoc_consts.vh"

module rtoc_prescaler
(
	input wire clk,
	input wire rstn,
	input wire ce,
	input wire run,
	input wire [2:0] prescale_select,
	output wire tick
);

reg [`RTOC_PSC_W-1:0] div_cnt;
wire [`RTOC_PSC_W-1:0] div_mask;

// ****************************************
// Divide by 1 to 128
// ****************************************
// Mask of the low bits that must all be one for a tick
assign div_mask = (7'h01 << prescale_select) - 7'h01;
assign tick = run & ((div_cnt & div_mask) == div_mask);

always @(posedge clk)
begin
	if (!rstn)
		div_cnt <= {`RTOC_PSC_W{1'b0}};
	else if (ce)
	begin
		if (!run)
			div_cnt <= {`RTOC_PSC_W{1'b0}};
		else
			div_cnt <= div_cnt + 7'h01;
	end
end

endmodule

//--- logic/rtoc_irq.v
// Interrupt status and mask for the reload timer.
// Assumes the event is a one-cycle pulse and write strobes are single cycles.
`timescale 1ns/1ps
`include "rtoc_consts.vh"

module rtoc_irq
(
	input wire clk,
	input wire rstn,
	input wire ce,
	input wire event_pulse,
	input wire status_w1c,
	input wire mask_we,
	input wire mask_wdata,
	output reg status,
	output reg mask,
	output reg irq
);

// ****************************************
// Sticky status, mask, level output
// ****************************************
always @(posedge clk)
begin
	if (!rstn)
	begin
		status <= 1'b0;
		mask <= 1'b0;
		irq <= 1'b0;
	end
	else if (ce)
	begin
		// A new event beats a clear in the same cycle
		if (event_pulse)
			status <= 1'b1;
		else if (status_w1c)
			status <= 1'b0;
		if (mask_we)
			mask <= mask_wdata;
		irq <= status & mask;
	end
end

endmodule

//--- dv/rtoc_pin.sv
// Far-side model of the timer output pin.
// Assumes tout_oe_n low means the timer drives the pin.
`timescale 1ns/1ps
module rtoc_pin
(
	input wire clk,
	input wire tout,
	input wire tout_oe_n,
	output wire level,
	output reg [15:0] edges
);
	reg last;
	// ********
	// Pin level
	// ********
	// The pull-up holds the line high while the timer lets go of it
	assign level = tout_oe_n ? 1'b1 : tout;
	initial edges = 16'h0000;
	initial last = 1'b1;
	always @(posedge clk)
	begin
		last <= level;
		if (level != last)
			edges <= edges + 16'h0001;
	end
endmodule

//--- dv/rtoc_sva.sv
// Checker for the timer's APB and output ports.
// Assumes no APB access while ce is low, so every access has one wait state.
`timescale 1ns/1ps
module rtoc_sva
(
	input wire clk,
	input wire rstn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire tout,
	input wire tout_oe_n,
	input wire irq
);
	// ********
	// Properties
	// ********
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	wire bad = paddr > 8'h10 || paddr[1:0] != 2'h0;
	wire wr = pready && pwrite && !pslverr;
	rdy_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
	rdy_wait_a: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready) else $error("wait state");
	rdy_idle_a: assert property (!(psel && penable) |-> !pready) else $error("pready unasked");
	err_map_a: assert property (pready |-> pslverr == bad) else $error("pslverr wrong");
	err_only_a: assert property (pslverr |-> pready) else $error("pslverr alone");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
	irq_mask_a: assert property (wr && paddr == 8'h10 && !pwdata[0] |-> ##2 !irq) else $error("irq masked");
	oe_ctrl_a: assert property (wr && paddr == 8'h00 |-> ##2 tout_oe_n == !$past(pwdata[8], 2)) else $error("oe");
	cover property (pready && pslverr);
	cover property ($rose(irq));
	cover property ($changed(tout));
endmodule

//--- dv/tb.sv
// Self-checking bench for the reload timer, driven over APB.
// Assumes rtoc_consts.vh is on the include path.
`timescale 1ns/1ps
`include "rtoc_consts.vh"
module tb;
	reg clk = 1'b0;
	reg rstn = 1'b0;
	reg ce = 1'b1;
	reg psel = 1'b0;
	reg penable = 1'b0;
	reg pwrite = 1'b0;
	reg [7:0] paddr = 8'h00;
	reg [31:0] pwdata = 32'h0;
	reg [31:0] rd;
	reg err;
	reg [15:0] e0;
	reg [2:0] ps [0:2];
	wire [31:0] prdata;
	wire pready, pslverr, tout, tout_oe_n, irq, level;
	wire [15:0] edges;
	integer errors = 0;
	integer checks = 0;
	integer cyc = 0;
	integer t0, i;
	rtoc_timer dut (.clk(clk), .rstn(rstn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tout(tout),
		.tout_oe_n(tout_oe_n), .irq(irq));
	rtoc_pin pin (.clk(clk), .tout(tout), .tout_oe_n(tout_oe_n), .level(level), .edges(edges));
	initial
	begin
		forever #2 clk = ~clk;
	end
	// ********
	// Tasks
	// ********
	task test_done;
		begin
			$display("errors %0d checks %0d", errors, checks);
			if (errors == 0 && checks > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	task cmp(input reg [31:0] g, input reg [31:0] e);
		begin
			checks = checks + 1;
			if (g !== e)
			begin
				errors = errors + 1;
				$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
			end
		end
	endtask
	task apb(input reg w, input reg [7:0] a, input reg [31:0] d);
		begin
			@(posedge clk);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge clk);
			penable <= 1'b1;
			@(posedge clk);
			// Only pready or the bench timeout ends this wait
			while (pready !== 1'b1)
				@(posedge clk);
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task rdc(input reg [7:0] a, input reg [31:0] e);
		begin
			apb(1'b0, a, 32'h0);
			cmp(rd, e);
		end
	endtask
	function [31:0] ctl(input reg en, input reg pol, input reg [2:0] p, input reg [2:0] m);
		ctl = {23'h0, 1'b1, en, pol, p, m};
	endfunction
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 3000)
		begin
			$display("CHECK FAILED %0t timeout", $time);
			errors = errors + 1;
			test_done;
		end
	end
	// ********
	// Tests
	// ********
	initial
	begin
		ps[0] = 3'h0;
		ps[1] = 3'h3;
		ps[2] = 3'h7;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		rdc(`RTOC_OFF_CTRL, 32'h0);
		rdc(`RTOC_OFF_COUNT, 32'h0);
		rdc(`RTOC_OFF_RELOAD, 32'hFFFF);
		rdc(`RTOC_OFF_STATUS, 32'h0);
		rdc(`RTOC_OFF_MASK, 32'h0);
		apb(1'b1, 8'h14, 32'hFFFFFFFF);
		cmp({31'h0, err}, 32'h1);
		rdc(8'h14, 32'h0);
		for (i = 0; i < 3; i = i + 1)
		begin
			apb(1'b1, `RTOC_OFF_CTRL, ctl(1'b0, 1'b0, ps[i], 3'h0));
			apb(1'b1, `RTOC_OFF_COUNT, 32'h5);
			apb(1'b1, `RTOC_OFF_RELOAD, 32'hB);
			apb(1'b1, `RTOC_OFF_MASK, 32'h1);
			apb(1'b1, `RTOC_OFF_CTRL, ctl(1'b1, 1'b0, ps[i], 3'h0));
			t0 = cyc;
			apb(1'b1, `RTOC_OFF_CTRL, ctl(1'b1, 1'b1, ps[i], 3'h0));
			while (irq !== 1'b1 && cyc < t0 + 900)
				@(posedge clk);
			cmp(cyc - t0, 6 * (1 << ps[i]) + 2);
			rdc(`RTOC_OFF_STATUS, 32'h1);
			rdc(`RTOC_OFF_COUNT, 32'h1);
			cmp({31'h0, level}, 32'h1);
			apb(1'b1, `RTOC_OFF_STATUS, 32'h1);
			rdc(`RTOC_OFF_STATUS, 32'h0);
		end
		apb(1'b1, `RTOC_OFF_CTRL, ctl(1'b0, 1'b0, 3'h1, 3'h1));
		apb(1'b1, `RTOC_OFF_COUNT, 32'h0);
		apb(1'b1, `RTOC_OFF_RELOAD, 32'h4);
		apb(1'b1, `RTOC_OFF_CTRL, ctl(1'b1, 1'b0, 3'h1, 3'h1));
		e0 = edges;
		repeat (29) @(posedge clk);
		// A low clock enable must hold off the reload due three cycles later
		ce <= 1'b0;
		repeat (20) @(posedge clk);
		cmp({16'h0, edges - e0}, 32'h4);
		ce <= 1'b1;
		rdc(`RTOC_OFF_STATUS, 32'h3);
		apb(1'b1, `RTOC_OFF_MASK, 32'h0);
		apb(1'b1, `RTOC_OFF_CTRL, ctl(1'b1, 1'b0, 3'h0, 3'h2));
		apb(1'b1, `RTOC_OFF_STATUS, 32'h1);
		repeat (20) @(posedge clk);
		rdc(`RTOC_OFF_STATUS, 32'h0);
		cmp({31'h0, irq}, 32'h0);
		test_done;
	end
endmodule
bind rtoc_timer rtoc_sva chk (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .tout(tout),
	.tout_oe_n(tout_oe_n), .irq(irq));
